// ==== src/eac_consts.svh ====
// Offsets, field positions and timing counts of the byte store controller
`ifndef EAC_CONSTS_SVH
`define EAC_CONSTS_SVH

`define EAC_OFS_CONTROL     6'h1f
`define EAC_OFS_DATA        6'h20
`define EAC_OFS_ADDR_LOW    6'h21
`define EAC_OFS_ADDR_HIGH   6'h22

`define EAC_BIT_READ        0
`define EAC_BIT_STROBE      1
`define EAC_BIT_MASTER      2
`define EAC_BIT_RDY_IE      3
`define EAC_BIT_PM0         4
`define EAC_BIT_PM1         5

`define EAC_ADDR_W          10
`define EAC_MEM_DEPTH       1024

`define EAC_MASTER_CYCLES   3'h4
`define EAC_WR_STALL        3'h2
`define EAC_RD_STALL        3'h4

// Programming times in microseconds, and oscillator cycles per write
`define EAC_T_ATOMIC_US     3400
`define EAC_T_SPLIT_US      1800
`define EAC_OSC_CYCLES      26368
`define EAC_CLK_MHZ         100
`define EAC_T_ATOMIC_CYC    (`EAC_T_ATOMIC_US * `EAC_CLK_MHZ)
`define EAC_T_SPLIT_CYC     (`EAC_T_SPLIT_US * `EAC_CLK_MHZ)

`endif

// ==== src/eac_countdown.sv ====
// Loadable down counter with a zero flag
`timescale 1ns/10ps
module eac_countdown #(
    parameter int W = 3
) (
    input  wire logic         mclk,   // Clock
    input  wire logic         rst,    // Synchronous reset
    input  wire logic         load,   // Load start value
    input  wire logic [W-1:0] value,  // Start value
    output logic              active  // Count not yet zero
);
    logic [W-1:0] count_reg;

    always_ff @(posedge mclk) begin
        if (rst) begin
            count_reg <= '0;
        end else if (load) begin
            count_reg <= value;
        end else if (count_reg != '0) begin
            count_reg <= count_reg - 1'b1;
        end
    end

    assign active = (count_reg != '0);
endmodule

// ==== src/eac_pkg.sv ====
// Types shared by the byte store controller
package eac_pkg;
    typedef enum logic [1:0] {
        EAC_PM_ATOMIC = 2'b00,
        EAC_PM_ERASE  = 2'b01,
        EAC_PM_WRITE  = 2'b10,
        EAC_PM_RSVD   = 2'b11
    } eac_mode_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } eac_io_t;

    typedef enum logic [1:0] {
        EAC_IDLE    = 2'b00,
        EAC_PROGRAM = 2'b01
    } eac_state_t;
endpackage

// ==== src/eac_prog_timer.sv ====
// Programming duration timer, held across reset so a started write finishes
`timescale 1ns/10ps
module eac_prog_timer (
    input  wire logic        mclk,   // Clock
    input  wire logic        start,  // Begin timing
    input  wire logic [18:0] cycles, // Duration in clock cycles
    output logic             busy,   // Timing in progress
    output logic             done    // Pulse at end of timing
);
    logic [18:0] left_reg = '0;

    always_ff @(posedge mclk) begin
        if (start) begin
            left_reg <= cycles;
        end else if (left_reg != '0) begin
            left_reg <= left_reg - 19'h1;
        end
    end

    assign busy = (left_reg != '0);
    assign done = (left_reg == 19'h1);
endmodule

// ==== src/eac_top.sv ====
// Byte store access controller: address, data and control registers
`timescale 1ns/10ps
`include "eac_consts.svh"

// Summary of operation
// - Ten-bit linear byte address over two registers
// - Reserved address and control bits read zero
// - Data register: write source, read result
// - Mode field selects atomic, erase or write
// - Mode writes ignored while strobe set
// - Reset clears mode unless programming
// - Ready interrupt while strobe clear, enabled, flash self-program idle
// - Master enable self-clears after four cycles
// - Strobe starts programming only with master
// - Strobe stays set until programming ends
// - Write start stalls CPU two cycles
// - Read fetches byte, stalls CPU four
// - No reads or address changes while busy
// - No programming while flash self-program runs
// - Programming time counted, not instantaneous
// - Reset does not abort a running write
module eac_top (
    input  wire logic               mclk,          // 100 MHz clock
    input  wire logic               rst,           // Synchronous reset, active high
    input  wire eac_pkg::eac_io_t   io,            // Register access from the core
    input  wire logic               global_ie,     // Core global interrupt enable
    input  wire logic               store_program_enable, // Flash self-program busy
    output logic [7:0]              rdata,         // Register read data
    output logic                    cpu_stall,     // Hold the core
    output logic                    ready_irq,     // Ready interrupt request
    output logic                    prog_busy      // Programming in progress
);
    logic [9:0]  nv_byte_address_reg;
    logic [7:0]  nv_byte_data_reg;
    logic [1:0]  program_mode_field_reg;
    logic        ready_irq_enable_reg;
    logic        write_strobe_reg;
    logic [7:0]  rdata_reg;
    logic        stall_reg;
    logic        irq_reg;
    logic        busy_reg;
    logic [7:0]  mem [0:`EAC_MEM_DEPTH-1];

    logic        wr_ctrl;
    logic        wr_data;
    logic        wr_alo;
    logic        wr_ahi;
    logic        rd_req;
    logic        master_write_enable;
    logic        start_prog;
    logic        timer_busy;
    logic        timer_done;
    logic        stall_active;
    logic [2:0]  stall_len;
    logic [18:0] prog_cycles;
    logic [7:0]  prog_byte;
    logic [7:0]  ctrl_view;

    assign wr_ctrl = io.wr && (io.addr == `EAC_OFS_CONTROL);
    assign wr_data = io.wr && (io.addr == `EAC_OFS_DATA);
    assign wr_alo  = io.wr && (io.addr == `EAC_OFS_ADDR_LOW);
    assign wr_ahi  = io.wr && (io.addr == `EAC_OFS_ADDR_HIGH);

    // Read strobe refused while a write is in progress
    assign rd_req = wr_ctrl && io.wdata[`EAC_BIT_READ] && !write_strobe_reg;

    // Start needs live master enable, idle strobe, flash not busy, legal mode
    assign start_prog = wr_ctrl && io.wdata[`EAC_BIT_STROBE] && master_write_enable
                        && !write_strobe_reg && !store_program_enable
                        && (program_mode_field_reg != eac_pkg::EAC_PM_RSVD) && !rst;

    always_comb begin
        unique case (eac_pkg::eac_mode_t'(program_mode_field_reg))
            eac_pkg::EAC_PM_ATOMIC: prog_cycles = 19'(`EAC_T_ATOMIC_CYC);
            eac_pkg::EAC_PM_ERASE:  prog_cycles = 19'(`EAC_T_SPLIT_CYC);
            eac_pkg::EAC_PM_WRITE:  prog_cycles = 19'(`EAC_T_SPLIT_CYC);
            eac_pkg::EAC_PM_RSVD:   prog_cycles = 19'(`EAC_T_SPLIT_CYC);
        endcase
    end

    // Master enable window: four cycles from the software write
    eac_countdown #(.W(3)) u_master (
        .mclk   (mclk),
        .rst    (rst),
        .load   (wr_ctrl && io.wdata[`EAC_BIT_MASTER]),
        .value  (`EAC_MASTER_CYCLES),
        .active (master_write_enable)
    );

    // Core stall after a read or a write start; load cycle counts as one
    assign stall_len = rd_req ? (`EAC_RD_STALL - 3'h1)
                              : (`EAC_WR_STALL - 3'h1);

    eac_countdown #(.W(3)) u_stall (
        .mclk   (mclk),
        .rst    (rst),
        .load   (rd_req || start_prog),
        .value  (stall_len),
        .active (stall_active)
    );

    // Timer ignores reset so a write in flight completes
    eac_prog_timer u_timer (
        .mclk   (mclk),
        .start  (start_prog),
        .cycles (prog_cycles),
        .busy   (timer_busy),
        .done   (timer_done)
    );

    // Strobe is busy flag for the whole programming time
    always_ff @(posedge mclk) begin
        if (start_prog) begin
            write_strobe_reg <= 1'b1;
        end else if (timer_done || (rst && !timer_busy)) begin
            write_strobe_reg <= 1'b0;
        end
    end

    // Mode field
    always_ff @(posedge mclk) begin
        if (rst) begin
            if (!timer_busy) begin
                program_mode_field_reg <= 2'h0;
            end
        end else if (wr_ctrl && !write_strobe_reg) begin
            program_mode_field_reg <= io.wdata[`EAC_BIT_PM1:`EAC_BIT_PM0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ready_irq_enable_reg <= 1'b0;
        end else if (wr_ctrl) begin
            ready_irq_enable_reg <= io.wdata[`EAC_BIT_RDY_IE];
        end
    end

    // Address: undefined at reset, frozen while programming
    always_ff @(posedge mclk) begin
        if (wr_alo && !write_strobe_reg) begin
            nv_byte_address_reg[7:0] <= io.wdata;
        end
        if (wr_ahi && !write_strobe_reg) begin
            nv_byte_address_reg[9:8] <= io.wdata[1:0];
        end
    end

    // Data register: loaded by software or by a read
    always_ff @(posedge mclk) begin
        if (rst) begin
            nv_byte_data_reg <= 8'h00;
        end else if (rd_req) begin
            nv_byte_data_reg <= mem[nv_byte_address_reg];
        end else if (wr_data) begin
            nv_byte_data_reg <= io.wdata;
        end
    end

    // Cell array: updated per latched mode (byte, erase value ff, or AND with byte) when the programming time ends
    always_ff @(posedge mclk) begin
        if (start_prog) begin
            prog_byte <= nv_byte_data_reg;
        end
    end

    logic [1:0] prog_mode_reg;

    always_ff @(posedge mclk) begin
        if (start_prog) begin
            prog_mode_reg <= program_mode_field_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (timer_done) begin
            unique case (eac_pkg::eac_mode_t'(prog_mode_reg))
                eac_pkg::EAC_PM_ATOMIC: mem[nv_byte_address_reg] <= prog_byte;
                eac_pkg::EAC_PM_ERASE:  mem[nv_byte_address_reg] <= 8'hff;
                eac_pkg::EAC_PM_WRITE:  mem[nv_byte_address_reg] <=
                                            mem[nv_byte_address_reg] & prog_byte;
                eac_pkg::EAC_PM_RSVD:   mem[nv_byte_address_reg] <= mem[nv_byte_address_reg];
            endcase
        end
    end

    assign ctrl_view = {2'h0, program_mode_field_reg, ready_irq_enable_reg,
                        master_write_enable, write_strobe_reg, 1'b0};

    // Register read mux
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else if (io.rd) begin
            unique case (io.addr)
                `EAC_OFS_CONTROL:   rdata_reg <= ctrl_view;
                `EAC_OFS_DATA:      rdata_reg <= nv_byte_data_reg;
                `EAC_OFS_ADDR_LOW:  rdata_reg <= nv_byte_address_reg[7:0];
                `EAC_OFS_ADDR_HIGH: rdata_reg <= {6'h00, nv_byte_address_reg[9:8]};
                default:            rdata_reg <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            stall_reg <= 1'b0;
        end else begin
            stall_reg <= rd_req || start_prog || stall_active;
        end
    end

    // Ready interrupt: level while idle, never during flash self-program
    always_ff @(posedge mclk) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= ready_irq_enable_reg && global_ie
                       && !write_strobe_reg && !start_prog && !store_program_enable;
        end
    end

    // Busy mirrors the strobe through reset, as a running write carries on
    always_ff @(posedge mclk) begin
        busy_reg <= write_strobe_reg || start_prog;
    end

    assign rdata     = rdata_reg;
    assign cpu_stall = stall_reg;
    assign ready_irq = irq_reg;
    assign prog_busy = busy_reg;
endmodule

// ==== test/eac_top_sva.sv ====
// Port checks of the byte store controller
`timescale 1ns/10ps
module eac_top_sva (
    input  wire logic             mclk,                 // Clock
    input  wire logic             rst,                  // Reset
    input  wire eac_pkg::eac_io_t io,                   // Core access
    input  wire logic             global_ie,            // Global enable
    input  wire logic             store_program_enable, // Flash busy
    input  wire logic [7:0]       rdata,                // Read data
    input  wire logic             cpu_stall,            // Stall
    input  wire logic             ready_irq,            // Ready request
    input  wire logic             prog_busy             // Busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_ctl_rd; io.rd && io.addr == 6'h1f; endsequence
    sequence s_start; $rose(prog_busy); endsequence
    sequence s_rd_req; io.wr && io.addr == 6'h1f && io.wdata[0] && !prog_busy; endsequence
    sequence s_stall2; cpu_stall[*2] ##1 !cpu_stall; endsequence
    sequence s_stall4; cpu_stall[*4] ##1 !cpu_stall; endsequence
    property p_hi_rsv; io.rd && io.addr == 6'h22 |=> rdata[7:2] == 6'h00; endproperty
    a_hi_rsv: assert property (p_hi_rsv) else $error("high address spare bits set");
    property p_ctl_rsv; s_ctl_rd |=> rdata[7:6] == 2'b00 && !rdata[0]; endproperty
    a_ctl_rsv: assert property (p_ctl_rsv) else $error("control spare bits set");
    property p_irq_busy; prog_busy && $past(prog_busy) |-> !ready_irq; endproperty
    a_irq_busy: assert property (p_irq_busy) else $error("ready irq while busy");
    property p_irq_gie; !global_ie && !$past(global_ie) |-> !ready_irq; endproperty
    a_irq_gie: assert property (p_irq_gie) else $error("ready irq while masked");
    property p_flash;
        !prog_busy && store_program_enable && $past(store_program_enable) |=> !prog_busy;
    endproperty
    a_flash: assert property (p_flash) else $error("start during flash write");
    property p_wr_stall; s_start |-> s_stall2; endproperty
    a_wr_stall: assert property (p_wr_stall) else $error("bad stall on write");
    property p_stall_end; cpu_stall |-> ##[1:4] !cpu_stall; endproperty
    a_stall_end: assert property (p_stall_end) else $error("stall too long");
    property p_rd_stall; s_rd_req |=> s_stall4; endproperty
    a_rd_stall: assert property (p_rd_stall) else $error("bad stall on read");
    property p_busy_hold; s_start |-> prog_busy[*8]; endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
    property p_keep; disable iff (1'b0) $rose(rst) && prog_busy |=> prog_busy; endproperty
    a_keep: assert property (p_keep) else $error("reset aborted write");
endmodule

bind eac_top eac_top_sva eac_top_sva_i (.mclk(mclk), .rst(rst), .io(io),
    .global_ie(global_ie), .store_program_enable(store_program_enable), .rdata(rdata),
    .cpu_stall(cpu_stall), .ready_irq(ready_irq), .prog_busy(prog_busy));

// ==== test/tb.sv ====
// Self-checking bench of the byte store controller
`timescale 1ns/10ps
module tb;
    logic             mclk;
    logic             rst;
    eac_pkg::eac_io_t io;
    logic             global_ie;
    logic             store_program_enable;
    logic [7:0]       rdata;
    logic             cpu_stall;
    logic             ready_irq;
    logic             prog_busy;
    logic [7:0]       notes[$];
    logic             rd_q = 1'b0;
    logic [7:0]       v;
    logic [7:0]       av;
    int               fails;
    int               checks;
    int               seed;
    eac_top eac_top_i (.mclk(mclk), .rst(rst), .io(io), .global_ie(global_ie),
        .store_program_enable(store_program_enable), .rdata(rdata),
        .cpu_stall(cpu_stall), .ready_irq(ready_irq), .prog_busy(prog_busy));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        cmp({7'h00, got}, {7'h00, exp});
    endtask
    task automatic access(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        io = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge mclk);
        #1;
        io = '0;
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        access(1'b1, a, d);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        notes.push_back(exp);
        access(1'b0, a, 8'h00);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Read data lands the cycle after the request
    always @(posedge mclk) begin
        if (rd_q === 1'b1) begin
            cmp(rdata, notes.pop_front());
        end
        rd_q <= io.rd;
    end
    initial begin
        #(10 * 5000);
        fails++;
        close_out();
    end
    initial begin
        seed = 32'h5382;
        io = '0;
        global_ie = 1'b0;
        store_program_enable = 1'b0;
        rst = 1'b1;
        settle(12);
        rst = 1'b0;
        rd(6'h1f, 8'h00);
        v = $random(seed);
        av = $random(seed);
        wr(6'h22, v);
        rd(6'h22, {6'h00, v[1:0]});
        wr(6'h21, av);
        rd(6'h21, av);
        for (int m = 0; m < 4; m++) begin
            wr(6'h1f, 8'(m << 4));
            rd(6'h1f, 8'(m << 4));
        end
        wr(6'h1f, 8'h34);
        wr(6'h1f, 8'h32);
        settle(3);
        cmp_flag(prog_busy, 1'b0);
        rd(6'h1f, 8'h30);
        wr(6'h1f, 8'h01);
        settle(1);
        cmp_flag(cpu_stall, 1'b1);
        settle(2);
        cmp_flag(cpu_stall, 1'b1);
        settle(1);
        cmp_flag(cpu_stall, 1'b0);
        wr(6'h1f, 8'h02);
        settle(3);
        cmp_flag(prog_busy, 1'b0);
        wr(6'h1f, 8'h04);
        rd(6'h1f, 8'h04);
        settle(6);
        rd(6'h1f, 8'h00);
        $display("test controls done");
        global_ie = 1'b1;
        wr(6'h1f, 8'h08);
        settle(2);
        cmp_flag(ready_irq, 1'b1);
        global_ie = 1'b0;
        settle(3);
        cmp_flag(ready_irq, 1'b0);
        global_ie = 1'b1;
        store_program_enable = 1'b1;
        wr(6'h1f, 8'h0c);
        wr(6'h1f, 8'h0a);
        settle(3);
        cmp_flag(prog_busy, 1'b0);
        cmp_flag(ready_irq, 1'b0);
        store_program_enable = 1'b0;
        wr(6'h20, v);
        rd(6'h20, v);
        $display("test refusals done");
        global_ie = 1'b0;
        wr(6'h1f, 8'h2c);
        wr(6'h1f, 8'h2a);
        cmp_flag(cpu_stall, 1'b1);
        settle(1);
        cmp_flag(cpu_stall, 1'b1);
        settle(1);
        cmp_flag(cpu_stall, 1'b0);
        global_ie = 1'b1;
        settle(2);
        cmp_flag(prog_busy, 1'b1);
        cmp_flag(ready_irq, 1'b0);
        wr(6'h21, ~av);
        rd(6'h21, av);
        wr(6'h1f, 8'h09);
        cmp_flag(cpu_stall, 1'b0);
        rd(6'h1f, 8'h2a);
        rd(6'h20, v);
        settle(2);
        rst = 1'b1;
        settle(12);
        rst = 1'b0;
        cmp_flag(prog_busy, 1'b1);
        rd(6'h1f, 8'h22);
        settle(2);
        $display("test programming done");
        close_out();
    end
endmodule
